// *** inc/ssc_pkg.sv ***
// Shared constants for the sync source and start-up control ends.
package ssc_pkg;
   // ----------------------------------------------------------------
   // Device configuration space
   // ----------------------------------------------------------------
   localparam int CFG_ADDR_W = 5;
   localparam int CFG_DATA_W = 8;
   localparam int CFG_DEPTH = 32;
   localparam int SHADOW_N = 8;
   localparam logic [4:0] REG_SYNC_CTRL = 5'h05;
   localparam logic [4:0] REG_SHADOW_FIRST = 5'h06;
   localparam logic [4:0] REG_SHADOW_LAST = 5'h0d;
   localparam logic [4:0] REG_OSC_CORR_SEL = 5'h16;
   localparam logic [4:0] REG_FIFO_SEL = 5'h17;
   localparam logic [7:0] CFG_RESET_VAL = 8'h00;
   // Sync control register fields.
   localparam int BIT_SW_SYNC = 0;
   localparam int BIT_CLKDIV_ENA = 1;
   localparam int BIT_CLKDIV_SEL = 2;
   localparam int FLD_XFER_LSB = 3;
   // Two-bit sync source codes.
   localparam logic [1:0] SRC_SOFT = 2'h0;
   localparam logic [1:0] SRC_ALIGN = 2'h1;
   localparam logic [1:0] SRC_TXEN = 2'h2;
   localparam logic [1:0] SRC_ZERO = 2'h3;
   // Three-bit buffer sync source codes.
   localparam logic [2:0] FIFO_SOFT = 3'h0;
   localparam logic [2:0] FIFO_ALIGN = 3'h1;
   localparam logic [2:0] FIFO_TXEN = 3'h2;
   localparam logic [2:0] FIFO_ZERO = 3'h3;
   localparam logic [7:0] OSC_CORR_ALIGN = 8'h55;
   localparam logic [7:0] OSC_CORR_TXEN = 8'haa;
   // ----------------------------------------------------------------
   // Host register map (APB byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam int CTL_RESET = 0;
   localparam int CTL_TOGGLE = 1;
   localparam int CTL_TXEN_LVL = 2;
   localparam int CTL_SEQ = 3;
   localparam int CTL_USE_TXEN = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_READ_BIT = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_SEQ_DONE = 1;
   localparam int ST_RST_DONE = 2;
   localparam int ST_RDATA_LSB = 8;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RESET_LOW_NS = 25;
   localparam int RESET_LOW_CYC_RAW = (RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_LOW_CYC = (RESET_LOW_CYC_RAW < 1) ? 1 : RESET_LOW_CYC_RAW;
   localparam int ALIGN_HOLD_CYC = 4;
   localparam int SEQ_STEPS = 8;

   typedef struct packed {
      logic toggle;
      logic [4:0] addr;
      logic [7:0] data;
   } ssc_step_t;
endpackage

// *** inc/ssc_link_if.sv ***
// Pin and configuration-port interface between host and converter.
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
   logic rst_pin_n;
   logic align_pin;
   logic txen_pin;
   logic cfg_wr;
   logic cfg_rd;
   logic [4:0] cfg_addr;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   logic cfg_ack;

   modport dev (
      input rst_pin_n, align_pin, txen_pin, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
      output cfg_rdata, cfg_ack
   );
   modport host (
      output rst_pin_n, align_pin, txen_pin, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
      input cfg_rdata, cfg_ack
   );
endinterface
`default_nettype wire

// *** core/ssc_device.sv ***
// Converter end: configuration store, sync source selection and block alignment.
//
// Contract
// [R1] Host holds reset pin low 25 ns minimum.
// [R2] Reset, clock, program, sync, then data.
// [R3] Sync from align pin, transmit enable, software.
// [R4] Registers six to thirteen update on sync.
// [R5] Multi-converter alignment avoids the software sync.
// [R6] Divider enable 1, source 0: align pin.
// [R7] Select value 0x55 maps align pin.
// [R8] Buffer source 001 pin, 011 zero.
// [R9] Three toggles: dividers, buffer, oscillator/correction.
// [R10] All converters toggled at the same moment.
// [R11] Transmit enable source needs remapped selects.
// [R12] Synchronised rising pin edge is one event.
`timescale 1ns/1ps
`default_nettype none
module ssc_device
   import ssc_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   ssc_link_if.dev link,
   output logic [63:0] active_cfg_out,
   output logic [DIV_W-1:0] clkdiv_phase_out,
   output logic clkdiv_align_out,
   output logic fifo_align_out,
   output logic osc_align_out,
   output logic corr_align_out,
   output logic xfer_out
);
   // ----------------------------------------------------------------
   // Source selection helper
   // ----------------------------------------------------------------
   function automatic logic pick_src(input logic [1:0] code, input logic sw,
                                     input logic al, input logic tx);
      logic r;
      r = 1'b0;
      case (code)
         SRC_SOFT: r = sw;
         SRC_ALIGN: r = al;
         SRC_TXEN: r = tx;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rst_s1_r, rst_s2_r;
   logic al_s1_r, al_s2_r, al_s3_r;
   logic tx_s1_r, tx_s2_r, tx_s3_r;
   logic al_rise, tx_rise;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= link.rst_pin_n;
         rst_s2_r <= rst_s1_r;
      end
   end

   // [R12] Two-stage pin sync.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         al_s1_r <= 1'b0;
         al_s2_r <= 1'b0;
         al_s3_r <= 1'b0;
         tx_s1_r <= 1'b0;
         tx_s2_r <= 1'b0;
         tx_s3_r <= 1'b0;
      end else begin
         al_s1_r <= link.align_pin;
         al_s2_r <= al_s1_r;
         al_s3_r <= al_s2_r;
         tx_s1_r <= link.txen_pin;
         tx_s2_r <= tx_s1_r;
         tx_s3_r <= tx_s2_r;
      end
   end

   // [R12] Rising edge detect.
   assign al_rise = al_s2_r & ~al_s3_r;
   assign tx_rise = tx_s2_r & ~tx_s3_r;

   // ----------------------------------------------------------------
   // Configuration store
   // ----------------------------------------------------------------
   logic [7:0] cfg_r [0:CFG_DEPTH-1];
   logic [7:0] act_r [0:SHADOW_N-1];
   logic sw_evt_r;
   logic [7:0] rdata_r;
   logic ack_r;
   logic [7:0] ctrl5;
   logic [7:0] sel22;
   logic [2:0] fifo_sel;

   assign ctrl5 = cfg_r[REG_SYNC_CTRL];
   assign sel22 = cfg_r[REG_OSC_CORR_SEL];
   assign fifo_sel = cfg_r[REG_FIFO_SEL][2:0];

   // The software sync bit is never stored, so it always reads back as zero.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < CFG_DEPTH; i++) begin
            cfg_r[i] <= CFG_RESET_VAL;
         end
      end else if (!rst_s2_r) begin
         for (int i = 0; i < CFG_DEPTH; i++) begin
            cfg_r[i] <= CFG_RESET_VAL;
         end
      end else if (link.cfg_wr) begin
         if (link.cfg_addr == REG_SYNC_CTRL) begin
            cfg_r[link.cfg_addr] <= link.cfg_wdata & ~(8'h01 << BIT_SW_SYNC);
         end else begin
            cfg_r[link.cfg_addr] <= link.cfg_wdata;
         end
      end
   end

   // [R3] Software sync pulse.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sw_evt_r <= 1'b0;
      end else begin
         sw_evt_r <= rst_s2_r & link.cfg_wr & (link.cfg_addr == REG_SYNC_CTRL) &
                     link.cfg_wdata[BIT_SW_SYNC];
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ack_r <= link.cfg_wr | link.cfg_rd;
         if (link.cfg_rd) begin
            rdata_r <= cfg_r[link.cfg_addr];
         end
      end
   end

   assign link.cfg_ack = ack_r;
   assign link.cfg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Sync event routing
   // ----------------------------------------------------------------
   logic clkdiv_evt, fifo_evt, osc_evt, corr_evt, xfer_evt;

   // [R6] Divider alignment source.
   assign clkdiv_evt = ctrl5[BIT_CLKDIV_ENA] & (ctrl5[BIT_CLKDIV_SEL] ? tx_rise : al_rise);

   // [R8] Buffer alignment source.
   always_comb begin
      fifo_evt = 1'b0;
      case (fifo_sel)
         FIFO_SOFT: fifo_evt = sw_evt_r;
         FIFO_ALIGN: fifo_evt = al_rise;
         FIFO_TXEN: fifo_evt = tx_rise;
         default: fifo_evt = 1'b0;
      endcase
   end

   // [R7] Oscillator and correction sources.
   assign osc_evt = pick_src(sel22[1:0], sw_evt_r, al_rise, tx_rise) |
                    pick_src(sel22[3:2], sw_evt_r, al_rise, tx_rise);
   assign corr_evt = pick_src(sel22[5:4], sw_evt_r, al_rise, tx_rise) |
                     pick_src(sel22[7:6], sw_evt_r, al_rise, tx_rise);

   // [R3] Control transfer source.
   assign xfer_evt = pick_src(ctrl5[FLD_XFER_LSB+1:FLD_XFER_LSB], sw_evt_r, al_rise, tx_rise);

   // [R4] Shadow to active copy.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < SHADOW_N; i++) begin
            act_r[i] <= CFG_RESET_VAL;
         end
      end else if (!rst_s2_r) begin
         for (int i = 0; i < SHADOW_N; i++) begin
            act_r[i] <= CFG_RESET_VAL;
         end
      end else if (xfer_evt) begin
         for (int i = 0; i < SHADOW_N; i++) begin
            act_r[i] <= cfg_r[i + int'(REG_SHADOW_FIRST)];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < SHADOW_N; g++) begin : g_act
         assign active_cfg_out[g*8 +: 8] = act_r[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Block alignment outputs
   // ----------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt_r;
   logic clkdiv_r, fifo_r, osc_r, corr_r, xfer_r;

   // [R6] Divider restarts on alignment.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_cnt_r <= '0;
      end else if (clkdiv_evt || !rst_s2_r) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clkdiv_r <= 1'b0;
         fifo_r <= 1'b0;
         osc_r <= 1'b0;
         corr_r <= 1'b0;
         xfer_r <= 1'b0;
      end else begin
         clkdiv_r <= clkdiv_evt;
         fifo_r <= fifo_evt;
         osc_r <= osc_evt;
         corr_r <= corr_evt;
         xfer_r <= xfer_evt;
      end
   end

   assign clkdiv_phase_out = div_cnt_r;
   assign clkdiv_align_out = clkdiv_r;
   assign fifo_align_out = fifo_r;
   assign osc_align_out = osc_r;
   assign corr_align_out = corr_r;
   assign xfer_out = xfer_r;
endmodule // ssc_device
`default_nettype wire

// *** core/ssc_host.sv ***
// Host end: APB registers, reset pulse, configuration writes and alignment sequence.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ssc_host
   import ssc_pkg::*;
#(
   parameter int HOLD_CYC = ALIGN_HOLD_CYC
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic busy_out,
   ssc_link_if.host link
);
   typedef enum {H_IDLE, H_RST, H_WR, H_WAIT, H_HI, H_LO} ssc_hstate_t;

   // ----------------------------------------------------------------
   // Alignment sequence table
   // ----------------------------------------------------------------
   function automatic ssc_step_t seq_step(input logic [2:0] idx, input logic use_tx);
      ssc_step_t s;
      logic [1:0] src;
      s = '0;
      src = use_tx ? SRC_TXEN : SRC_ALIGN;
      case (idx)
         3'd0: s = '{1'b0, REG_SYNC_CTRL, {3'b000, src, use_tx, 1'b1, 1'b0}};
         3'd1: s = '{1'b0, REG_OSC_CORR_SEL, use_tx ? OSC_CORR_TXEN : OSC_CORR_ALIGN};
         3'd2: s = '{1'b0, REG_FIFO_SEL, {5'b00000, use_tx ? FIFO_TXEN : FIFO_ALIGN}};
         3'd4: s = '{1'b0, REG_SYNC_CTRL, {3'b000, src, use_tx, 1'b0, 1'b0}};
         3'd6: s = '{1'b0, REG_FIFO_SEL, {5'b00000, FIFO_ZERO}};
         default: s = '{1'b1, 5'h00, 8'h00};
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic acc, wr_ctrl, wr_cmd, mapped;
   logic [31:0] prdata_r;
   logic txen_lvl_r, seq_done_r, rst_done_r;
   logic [7:0] rdata_r;
   ssc_hstate_t state_r;

   assign acc = psel_in & penable_in;
   assign mapped = (paddr_in == OFF_CTRL) || (paddr_in == OFF_CMD) || (paddr_in == OFF_STATUS);
   assign wr_ctrl = acc & pwrite_in & (paddr_in == OFF_CTRL);
   assign wr_cmd = acc & pwrite_in & (paddr_in == OFF_CMD);
   assign pready_out = 1'b1;
   assign pslverr_out = acc & ~mapped;
   assign prdata_out = prdata_r;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel_in && !penable_in) begin
         if (paddr_in == OFF_CTRL) begin
            prdata_r <= 32'h0000_0000 | ({31'h0000_0000, txen_lvl_r} << CTL_TXEN_LVL);
         end else if (paddr_in == OFF_STATUS) begin
            prdata_r <= ({24'h00_0000, rdata_r} << ST_RDATA_LSB) |
                        ({31'h0000_0000, rst_done_r} << ST_RST_DONE) |
                        ({31'h0000_0000, seq_done_r} << ST_SEQ_DONE) |
                        ({31'h0000_0000, busy_out} << ST_BUSY);
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         txen_lvl_r <= 1'b0;
      end else if (wr_ctrl) begin
         txen_lvl_r <= pwdata_in[CTL_TXEN_LVL];
      end
   end

   // ----------------------------------------------------------------
   // Pin and command sequencer
   // ----------------------------------------------------------------
   logic [15:0] cnt_r;
   logic [2:0] step_r;
   logic seq_r, use_tx_r, rd_op_r, pulse_r;
   logic wr_r, rd_r;
   logic [4:0] addr_r;
   logic [7:0] wdata_r;
   logic rst_pin_r;
   ssc_step_t nxt;
   ssc_step_t head;

   assign nxt = seq_step(step_r + 3'd1, use_tx_r);
   assign head = seq_step(3'd0, pwdata_in[CTL_USE_TXEN]);
   assign busy_out = (state_r != H_IDLE);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= H_IDLE;
         cnt_r <= 16'h0000;
         step_r <= 3'd0;
         seq_r <= 1'b0;
         use_tx_r <= 1'b0;
         rd_op_r <= 1'b0;
         pulse_r <= 1'b0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         addr_r <= 5'h00;
         wdata_r <= 8'h00;
         rst_pin_r <= 1'b1;
         seq_done_r <= 1'b0;
         rst_done_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         case (state_r)
            H_IDLE: begin
               // [R1] Start reset pulse.
               if (wr_ctrl && pwdata_in[CTL_RESET]) begin
                  rst_pin_r <= 1'b0;
                  rst_done_r <= 1'b0;
                  cnt_r <= 16'(RESET_LOW_CYC);
                  state_r <= H_RST;
               // [R9] Start alignment sequence.
               end else if (wr_ctrl && pwdata_in[CTL_SEQ]) begin
                  // [R5] Pin sources only.
                  use_tx_r <= pwdata_in[CTL_USE_TXEN];
                  seq_r <= 1'b1;
                  seq_done_r <= 1'b0;
                  step_r <= 3'd0;
                  addr_r <= head.addr;
                  wdata_r <= head.data;
                  rd_op_r <= 1'b0;
                  wr_r <= 1'b1;
                  state_r <= H_WR;
               end else if (wr_ctrl && pwdata_in[CTL_TOGGLE]) begin
                  // [R11] Transmit enable as source.
                  use_tx_r <= pwdata_in[CTL_USE_TXEN];
                  pulse_r <= 1'b1;
                  cnt_r <= 16'(HOLD_CYC);
                  state_r <= H_HI;
               end else if (wr_cmd) begin
                  addr_r <= pwdata_in[CMD_ADDR_LSB +: 5];
                  wdata_r <= pwdata_in[7:0];
                  rd_op_r <= pwdata_in[CMD_READ_BIT];
                  wr_r <= ~pwdata_in[CMD_READ_BIT];
                  rd_r <= pwdata_in[CMD_READ_BIT];
                  state_r <= H_WR;
               end
            end
            H_RST: begin
               cnt_r <= cnt_r - 16'h0001;
               if (cnt_r == 16'h0001) begin
                  rst_pin_r <= 1'b1;
                  rst_done_r <= 1'b1;
                  state_r <= H_IDLE;
               end
            end
            H_WR: begin
               state_r <= H_WAIT;
            end
            H_WAIT: begin
               if (link.cfg_ack) begin
                  if (rd_op_r) begin
                     rdata_r <= link.cfg_rdata;
                  end
                  if (seq_r) begin
                     step_r <= step_r + 3'd1;
                     if (nxt.toggle) begin
                        pulse_r <= 1'b1;
                        cnt_r <= 16'(HOLD_CYC);
                        state_r <= H_HI;
                     end else begin
                        addr_r <= nxt.addr;
                        wdata_r <= nxt.data;
                        wr_r <= 1'b1;
                        state_r <= H_WR;
                     end
                  end else begin
                     state_r <= H_IDLE;
                  end
               end
            end
            H_HI: begin
               cnt_r <= cnt_r - 16'h0001;
               if (cnt_r == 16'h0001) begin
                  pulse_r <= 1'b0;
                  cnt_r <= 16'(HOLD_CYC);
                  state_r <= H_LO;
               end
            end
            H_LO: begin
               cnt_r <= cnt_r - 16'h0001;
               if (cnt_r == 16'h0001) begin
                  // [R9] Next step after toggle.
                  if (seq_r && step_r != 3'(SEQ_STEPS - 1)) begin
                     step_r <= step_r + 3'd1;
                     addr_r <= nxt.addr;
                     wdata_r <= nxt.data;
                     wr_r <= 1'b1;
                     state_r <= H_WR;
                  end else begin
                     seq_done_r <= seq_r;
                     seq_r <= 1'b0;
                     state_r <= H_IDLE;
                  end
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   // [R2] Reset held until released.
   assign link.rst_pin_n = rst_pin_r;
   // [R10] Single pulse drives all converters.
   assign link.align_pin = pulse_r & ~use_tx_r;
   assign link.txen_pin = txen_lvl_r | (pulse_r & use_tx_r);
   assign link.cfg_wr = wr_r;
   assign link.cfg_rd = rd_r;
   assign link.cfg_addr = addr_r;
   assign link.cfg_wdata = wdata_r;
endmodule // ssc_host
`default_nettype wire

// *** tb/ssc_checker.sv ***
// Concurrent checks on the host to converter link and the alignment pulses.
`timescale 1ns/1ps
`default_nettype none
module ssc_checker (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic rst_pin_n,
   input wire logic align_pin,
   input wire logic txen_pin,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic cfg_ack,
   input wire logic clkdiv_align_out,
   input wire logic fifo_align_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_strobe;
      cfg_wr || cfg_rd;
   endsequence
   sequence s_ack_once;
      cfg_ack ##1 !cfg_ack;
   endsequence
   property p_ack_after_strobe;
      s_strobe |=> s_ack_once;
   endproperty
   property p_ack_cause;
      cfg_ack |-> $past(cfg_wr || cfg_rd);
   endproperty
   property p_reset_quiet;
      $fell(rst_pin_n) |-> !cfg_wr && !cfg_rd && !align_pin;
   endproperty
   property p_align_high;
      $rose(align_pin) |-> align_pin [*2];
   endproperty
   property p_align_low;
      $fell(align_pin) |-> !align_pin [*2];
   endproperty
   property p_clkdiv_cause;
      clkdiv_align_out |-> ($past(align_pin, 3) && !$past(align_pin, 4)) ||
         ($past(txen_pin, 3) && !$past(txen_pin, 4));
   endproperty
   property p_clkdiv_single;
      clkdiv_align_out |=> !clkdiv_align_out;
   endproperty
   property p_fifo_single;
      $rose(fifo_align_out) |=> $fell(fifo_align_out);
   endproperty
   a_ack_after_strobe: assert property (p_ack_after_strobe) else $error("ack missing");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
   a_reset_quiet: assert property (p_reset_quiet) else $error("pins busy at reset");
   a_align_high: assert property (p_align_high) else $error("align high too short");
   a_align_low: assert property (p_align_low) else $error("align low too short");
   a_clkdiv_cause: assert property (p_clkdiv_cause) else $error("divider pulse no edge");
   a_clkdiv_single: assert property (p_clkdiv_single) else $error("divider pulse long");
   a_fifo_single: assert property (p_fifo_single) else $error("buffer pulse long");
endmodule // ssc_checker
`default_nettype wire

// *** tb/ssc_tb_top.sv ***
// Self-checking bench for the host and converter ends joined by the link.
`timescale 1ns/1ps
`default_nettype none
module ssc_tb_top import ssc_pkg::*;;
   logic clk_sys_in, nrst_in, psel_in, penable_in, pwrite_in;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out;
   logic pready_out, pslverr_out, busy_out;
   logic [63:0] active_cfg_out;
   logic [2:0] clkdiv_phase_out;
   logic [4:0] pv;
   int np[5];
   int n_rlow, n_fail, tests_run;
   ssc_link_if u_link ();
   ssc_host #(.HOLD_CYC(4)) u_ssc_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .busy_out(busy_out), .link(u_link.host));
   ssc_device #(.DIV_W(3)) u_ssc_device (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .link(u_link.dev), .active_cfg_out(active_cfg_out), .clkdiv_phase_out(clkdiv_phase_out),
      .clkdiv_align_out(pv[0]), .fifo_align_out(pv[1]), .osc_align_out(pv[2]),
      .corr_align_out(pv[3]), .xfer_out(pv[4]));
   ssc_checker u_ssc_checker (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .rst_pin_n(u_link.rst_pin_n), .align_pin(u_link.align_pin), .txen_pin(u_link.txen_pin),
      .cfg_wr(u_link.cfg_wr), .cfg_rd(u_link.cfg_rd), .cfg_ack(u_link.cfg_ack),
      .clkdiv_align_out(pv[0]), .fifo_align_out(pv[1]));
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   // Counts of alignment pulses and of reset pin low cycles.
   always @(posedge clk_sys_in) begin
      for (int k = 0; k < 5; k++) np[k] += (pv[k] === 1'b1);
      n_rlow += (u_link.rst_pin_n === 1'b0);
      if (pv[0] === 1'b1) chk(64'(clkdiv_phase_out), 64'h0);
   end
   // ----------------------------------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int i;
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys_in);
         if (pready_out === 1'b1) break;
      end
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (i == 50) begin
         chk(64'(pready_out), 64'h1);
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask
   task automatic idle();
      logic [31:0] q;
      int i;
      for (i = 0; i < 100; i++) begin
         rd(OFF_STATUS, q);
         if (q[ST_BUSY] === 1'b0) break;
      end
      if (i == 100) begin
         chk(64'(q[ST_BUSY]), 64'h0);
         stop_test();
      end
   endtask
   task automatic cfg(input logic [4:0] a, input logic [7:0] d);
      wr(OFF_CMD, {16'h0000, 3'h0, a, d});
      idle();
   endtask
   task automatic cfg_get(input logic [4:0] a, output logic [7:0] v);
      logic [31:0] q;
      wr(OFF_CMD, {15'h0000, 1'b1, 3'h0, a, 8'h00});
      idle();
      rd(OFF_STATUS, q);
      v = q[15:8];
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] q;
      wr(OFF_CTRL, 32'h0000_0001);
      @(posedge clk_sys_in);
      chk(busy_out, 1'b1);
      idle();
      rd(OFF_STATUS, q);
      chk(busy_out, 1'b0);
      chk(64'(n_rlow >= RESET_LOW_CYC), 64'h1);
      chk(q[ST_RST_DONE], 1'b1);
   endtask
   task automatic t_shadow();
      logic [7:0] v;
      int x;
      for (int i = 0; i < 8; i++) cfg(REG_SHADOW_FIRST + 5'(i), 8'(8'h11 * (i + 1)));
      chk(active_cfg_out, 64'h0000_0000_0000_0000);
      cfg_get(REG_SHADOW_LAST, v);
      chk(v, 8'h88);
      x = np[4];
      cfg(REG_SYNC_CTRL, 8'h01);
      chk(active_cfg_out, 64'h8877_6655_4433_2211);
      chk(64'(np[4] - x), 64'h1);
      cfg_get(REG_SYNC_CTRL, v);
      chk(v, 8'h00);
   endtask
   task automatic t_pin(input logic [7:0] src, input logic [7:0] d, input logic [31:0] c);
      int x;
      cfg(REG_SYNC_CTRL, src);
      cfg(REG_SHADOW_FIRST, d);
      chk(active_cfg_out[7:0], 8'h11);
      x = np[4];
      wr(OFF_CTRL, c);
      idle();
      wr(OFF_CTRL, 32'h0000_0000);
      idle();
      chk(active_cfg_out[7:0], d);
      chk(64'(np[4] - x), 64'h1);
      cfg(REG_SHADOW_FIRST, 8'h11);
      cfg(REG_SYNC_CTRL, 8'h01);
   endtask
   task automatic t_seq(input logic [31:0] c, input logic [7:0] sel, input logic more);
      int b[5];
      logic [31:0] q;
      logic [7:0] v;
      b = np;
      wr(OFF_CTRL, c);
      idle();
      rd(OFF_STATUS, q);
      chk(q[ST_SEQ_DONE], 1'b1);
      chk({32'(np[0] - b[0]), 32'(np[1] - b[1])}, {32'h1, 32'h2});
      chk({32'(np[2] - b[2]), 32'(np[3] - b[3])}, {32'h3, 32'h3});
      cfg_get(REG_OSC_CORR_SEL, v);
      chk(v, sel);
      cfg_get(REG_FIFO_SEL, v);
      chk(v[2:0], FIFO_ZERO);
      if (more) begin
         b = np;
         wr(OFF_CTRL, 32'h0000_0002);
         idle();
         chk({32'(np[0] - b[0]), 32'(np[1] - b[1])}, {32'h0, 32'h0});
         chk(32'(np[2] - b[2]), 32'h1);
      end
   endtask
   task automatic t_err();
      logic [31:0] q;
      logic e;
      apb(1'b1, 8'h0c, 32'h0000_0001, q, e);
      chk(e, 1'b1);
   endtask
   initial begin
      nrst_in = 1'b0;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0000_0000;
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_reset();
      t_shadow();
      t_pin(8'h08, 8'ha5, 32'h0000_0002);
      t_pin(8'h10, 8'h5a, 32'h0000_0004);
      t_seq(32'h0000_0008, OSC_CORR_ALIGN, 1'b1);
      t_seq(32'h0000_0018, OSC_CORR_TXEN, 1'b0);
      t_err();
      stop_test();
   end
endmodule // ssc_tb_top
`default_nettype wire
